// [core/dcache_coh_pkg.sv]
// Purpose: Shared constants and types for the data-cache coherence block
// Assumes: 8 segments x 64 lines, 8 words per line, one core clock
// Notes:   No software-visible registers; ops arrive already decoded
package dcache_coh_pkg;
  localparam int          SEG_W        = 3;
  localparam int          IDX_W        = 6;
  localparam int          LINE_W       = 9;
  localparam int          NUM_LINES    = 512;
  localparam int          PTAG_W       = 26;
  localparam logic [5:0]  IDX_MAX      = 6'h3F;
  localparam logic [5:0]  BASE_RST     = 6'h00;
  localparam logic [5:0]  VICTIM_RST   = 6'h00;
  localparam logic [7:0]  PID_RST      = 8'h00;
  localparam logic [3:0]  WB_LEN_HALF  = 4'h4;
  localparam logic [3:0]  WB_LEN_FULL  = 4'h8;
  localparam logic [4:0]  HALF_OFFSET  = 5'h10;
  localparam logic [4:0]  LINE_OFFSET  = 5'h00;
  localparam logic [1:0]  IFETCH_AHEAD = 2'h3;
  localparam int          PTAG_LSB     = 6;
  localparam int          CTRL_DC_BIT  = 0;
  localparam int          CTRL_IC_BIT  = 1;

  typedef enum logic [3:0] {
    OP_NOP          = 4'b0000,
    OP_READ_HIT     = 4'b0001,
    OP_WRITE_HIT    = 4'b0010,
    OP_LINEFILL     = 4'b0011,
    OP_IFILL        = 4'b0100,
    OP_CLEAN_IDX    = 4'b0101,
    OP_CLEAN_INV_IDX= 4'b0110,
    OP_CLEAN_VA     = 4'b0111,
    OP_CLEAN_INV_VA = 4'b1000,
    OP_INV_D_LINE   = 4'b1001,
    OP_INV_D_ALL    = 4'b1010,
    OP_INV_I_ALL    = 4'b1011,
    OP_INV_I_LINE   = 4'b1100,
    OP_SET_BASE     = 4'b1101,
    OP_SET_PID      = 4'b1110,
    OP_SET_CTRL     = 4'b1111
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WB_READ = 3'b001,
    ST_WB_BUS  = 3'b010,
    ST_FILL    = 3'b011,
    ST_FINISH  = 3'b100
  } state_t;
endpackage : dcache_coh_pkg

// [core/ptag_if.sv]
// Purpose: Carrier between the coherence controller and the physical tag store
// Assumes: Read is combinational, write lands on the next clock edge
// Notes:   Line number is {segment, index}
`timescale 1ns/10ps
interface ptag_if;
  import dcache_coh_pkg::*;
  logic              wr_en;
  logic [LINE_W-1:0] wr_line;
  logic [PTAG_W-1:0] wr_tag;
  logic [LINE_W-1:0] rd_line;
  logic [PTAG_W-1:0] rd_tag;
  modport ctrl  (output wr_en, output wr_line, output wr_tag, output rd_line, input rd_tag);
  modport store (input wr_en, input wr_line, input wr_tag, input rd_line, output rd_tag);
endinterface : ptag_if

// [core/physical_tag_store.sv]
// Purpose: Physical tag store with scan and bus-side test access
// Assumes: Scan and test inputs are synchronous to the core clock
// Notes:   Functional write wins over a test write in the same cycle
`timescale 1ns/10ps
module physical_tag_store
  import dcache_coh_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Functional port
  ptag_if.store                  tag,
  // Bus-side test port
  input  wire logic              i_test_en,
  input  wire logic              i_test_wr,
  input  wire logic [LINE_W-1:0] i_test_line,
  input  wire logic [PTAG_W-1:0] i_test_wdata,
  output logic      [PTAG_W-1:0] o_test_rdata,
  // Scan chain: {line, tag}
  input  wire logic              i_scan_shift,
  input  wire logic              i_scan_in,
  input  wire logic              i_scan_capture,
  input  wire logic              i_scan_update,
  output logic                   o_scan_out
);
  typedef struct packed {
    logic [LINE_W+PTAG_W-1:0] scan_sr;
    logic [PTAG_W-1:0]        test_rdata;
  } ts_t;

  logic [PTAG_W-1:0] mem [NUM_LINES];
  ts_t               r_reg;
  ts_t               r_next;
  logic [LINE_W-1:0] scan_line;

  assign scan_line  = r_reg.scan_sr[LINE_W+PTAG_W-1:PTAG_W];
  assign tag.rd_tag = mem[tag.rd_line];
  assign o_test_rdata = r_reg.test_rdata;
  assign o_scan_out   = r_reg.scan_sr[0];

  always_comb
  begin
    r_next = r_reg;
    if (i_test_en && !i_test_wr)
    begin
      r_next.test_rdata = mem[i_test_line];
    end
    if (i_scan_capture)
    begin
      r_next.scan_sr[PTAG_W-1:0] = mem[scan_line];
    end
    else if (i_scan_shift)
    begin
      r_next.scan_sr = {i_scan_in, r_reg.scan_sr[LINE_W+PTAG_W-1:1]};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Tag contents need no reset; valid bits in the controller guard them
  always_ff @(posedge i_clk)
  begin
    if (tag.wr_en)
    begin
      mem[tag.wr_line] <= tag.wr_tag;
    end
    else if (i_test_en && i_test_wr)
    begin
      mem[i_test_line] <= i_test_wdata;
    end
    else if (i_scan_update)
    begin
      mem[scan_line] <= r_reg.scan_sr[PTAG_W-1:0];
    end
  end
endmodule : physical_tag_store

// [core/dcache_coherence.sv]
// Purpose: Dirty tracking, maintenance, victim pointer and write-back control
// Assumes: Hit detection and data arrays sit outside; ops arrive pre-resolved
// Notes:   Round-robin victim selection only
`timescale 1ns/10ps
module dcache_coherence
  import dcache_coh_pkg::*;
(
  // Clock and reset
  input  wire logic               I_SYS_CLK,
  input  wire logic               I_RST,
  // Operation request
  input  wire logic               I_OP_VALID,
  input  wire logic [3:0]         I_OP_CODE,
  input  wire logic [SEG_W-1:0]   I_SEG,
  input  wire logic [IDX_W-1:0]   I_INDEX,
  input  wire logic [31:0]        I_PA,
  input  wire logic [7:0]         I_DATA,
  input  wire logic               I_CACHEABLE,
  input  wire logic               I_BUFFERABLE,
  input  wire logic               I_HALF_HI,
  input  wire logic               I_IFETCH,
  output logic                    O_OP_READY,
  output logic                    O_OP_DONE,
  // Core-side access results
  output logic                    O_USE_CACHE,
  output logic                    O_CACHE_WR,
  output logic                    O_BUS_RD,
  output logic                    O_BUS_WR,
  // Write-back and linefill to the bus interface
  output logic                    O_WB_REQ,
  output logic [31:0]             O_WB_ADDR,
  output logic [3:0]              O_WB_LEN,
  input  wire logic               I_WB_DONE,
  output logic                    O_FILL_REQ,
  output logic [LINE_W-1:0]       O_FILL_LINE,
  input  wire logic               I_FILL_DONE,
  // Status
  output logic                    O_DC_EN,
  output logic                    O_IC_EN,
  output logic [IDX_W-1:0]        O_BASE,
  output logic [IDX_W-1:0]        O_VICTIM,
  output logic [7:0]              O_PID,
  output logic                    O_LK_DC_VALID,
  output logic                    O_LK_DC_DIRTY,
  output logic                    O_LK_IC_VALID,
  // Tag store test access
  input  wire logic               I_TEST_EN,
  input  wire logic               I_TEST_WR,
  input  wire logic [LINE_W-1:0]  I_TEST_LINE,
  input  wire logic [PTAG_W-1:0]  I_TEST_WDATA,
  output logic      [PTAG_W-1:0]  O_TEST_RDATA,
  input  wire logic               I_SCAN_SHIFT,
  input  wire logic               I_SCAN_IN,
  input  wire logic               I_SCAN_CAPTURE,
  input  wire logic               I_SCAN_UPDATE,
  output logic                    O_SCAN_OUT
);
  typedef struct packed {
    state_t                fsm;
    op_t                   op;
    logic [SEG_W-1:0]      seg;
    logic [IDX_W-1:0]      idx;
    logic [31:0]           pa;
    logic                  wb_attr;
    logic [IDX_W-1:0]      base;
    logic [IDX_W-1:0]      victim;
    logic [7:0]            pid;
    logic                  dc_en;
    logic                  ic_en;
    logic [NUM_LINES-1:0]  dc_valid;
    logic [NUM_LINES-1:0]  dirty_lo;
    logic [NUM_LINES-1:0]  dirty_hi;
    logic [NUM_LINES-1:0]  dc_wb;
    logic [NUM_LINES-1:0]  ic_valid;
    logic                  ic_pend;
    logic [1:0]            ic_cnt;
    logic                  ic_all;
    logic [LINE_W-1:0]     ic_line;
    logic                  done;
    logic                  use_cache;
    logic                  cache_wr;
    logic                  bus_rd;
    logic                  bus_wr;
    logic [31:0]           wb_addr;
    logic [3:0]            wb_len;
    logic                  lk_dc_valid;
    logic                  lk_dc_dirty;
    logic                  lk_ic_valid;
  } st_t;

  st_t               r_reg;
  st_t               r_next;
  logic [LINE_W-1:0] cur_line;
  logic [LINE_W-1:0] in_line;
  op_t               in_op;

  ptag_if tag_bus ();

  function automatic logic [LINE_W-1:0] line_of(input logic [SEG_W-1:0] s,
                                                input logic [IDX_W-1:0] i);
    line_of = {s, i};
  endfunction : line_of

  function automatic logic is_inv(input op_t o);
    is_inv = (o == OP_CLEAN_INV_IDX) || (o == OP_CLEAN_INV_VA);
  endfunction : is_inv

  assign in_op    = op_t'(I_OP_CODE);
  assign cur_line = line_of(r_reg.seg, r_reg.idx);
  assign in_line  = line_of(I_SEG, I_INDEX);

  assign tag_bus.rd_line = cur_line;
  assign tag_bus.wr_en   = (r_reg.fsm == ST_FILL) && I_FILL_DONE;
  assign tag_bus.wr_line = cur_line;
  assign tag_bus.wr_tag  = r_reg.pa[31:PTAG_LSB];

  physical_tag_store u_tag_store (
    .i_clk          (I_SYS_CLK),
    .i_rst          (I_RST),
    .tag            (tag_bus.store),
    .i_test_en      (I_TEST_EN),
    .i_test_wr      (I_TEST_WR),
    .i_test_line    (I_TEST_LINE),
    .i_test_wdata   (I_TEST_WDATA),
    .o_test_rdata   (O_TEST_RDATA),
    .i_scan_shift   (I_SCAN_SHIFT),
    .i_scan_in      (I_SCAN_IN),
    .i_scan_capture (I_SCAN_CAPTURE),
    .i_scan_update  (I_SCAN_UPDATE),
    .o_scan_out     (O_SCAN_OUT)
  );

  always_comb
  begin
    r_next          = r_reg;
    r_next.done     = 1'b0;
    r_next.cache_wr = 1'b0;
    r_next.bus_rd   = 1'b0;
    r_next.bus_wr   = 1'b0;
    r_next.lk_dc_valid = r_reg.dc_valid[in_line];
    r_next.lk_dc_dirty = r_reg.dirty_lo[in_line] | r_reg.dirty_hi[in_line];
    r_next.lk_ic_valid = r_reg.ic_valid[in_line];
    // Prefetched fetches still see the old lines until the countdown ends
    if (r_reg.ic_pend && I_IFETCH)
    begin
      if (r_reg.ic_cnt == 2'h1)
      begin
        r_next.ic_pend = 1'b0;
        if (r_reg.ic_all)
        begin
          r_next.ic_valid = '0;
        end
        else
        begin
          r_next.ic_valid[r_reg.ic_line] = 1'b0;
        end
      end
      else
      begin
        r_next.ic_cnt = r_reg.ic_cnt - 2'h1;
      end
    end
    case (r_reg.fsm)
      ST_IDLE:
      begin
        if (I_OP_VALID)
        begin
          r_next.op      = in_op;
          r_next.seg     = I_SEG;
          r_next.idx     = I_INDEX;
          r_next.pa      = I_PA;
          r_next.wb_attr = I_CACHEABLE & I_BUFFERABLE;
          case (in_op)
            OP_READ_HIT:
            begin
              r_next.use_cache = I_CACHEABLE;
              r_next.bus_rd    = ~I_CACHEABLE;
              r_next.done      = 1'b1;
            end
            OP_WRITE_HIT:
            begin
              r_next.cache_wr = 1'b1;
              if (I_CACHEABLE && I_BUFFERABLE)
              begin
                if (I_HALF_HI)
                begin
                  r_next.dirty_hi[in_line] = 1'b1;
                end
                else
                begin
                  r_next.dirty_lo[in_line] = 1'b1;
                end
              end
              else
              begin
                r_next.bus_wr = 1'b1;
              end
              r_next.done = 1'b1;
            end
            OP_LINEFILL:
            begin
              r_next.idx = r_reg.victim;
              if (r_reg.dc_valid[line_of(I_SEG, r_reg.victim)] &&
                  r_reg.dc_wb[line_of(I_SEG, r_reg.victim)] &&
                  (r_reg.dirty_lo[line_of(I_SEG, r_reg.victim)] ||
                   r_reg.dirty_hi[line_of(I_SEG, r_reg.victim)]))
              begin
                r_next.fsm = ST_WB_READ;
              end
              else
              begin
                r_next.fsm = ST_FILL;
              end
            end
            OP_IFILL:
            begin
              r_next.ic_valid[in_line] = 1'b1;
              r_next.done = 1'b1;
            end
            OP_CLEAN_IDX, OP_CLEAN_INV_IDX, OP_CLEAN_VA, OP_CLEAN_INV_VA:
            begin
              if ((in_op == OP_CLEAN_IDX) || (in_op == OP_CLEAN_INV_IDX))
              begin
                r_next.victim = I_INDEX;
              end
              // Address-based forms leave the pointer where it was
              if (r_reg.dc_valid[in_line] &&
                  (r_reg.dirty_lo[in_line] || r_reg.dirty_hi[in_line]))
              begin
                r_next.fsm = ST_WB_READ;
              end
              else
              begin
                r_next.fsm = ST_FINISH;
              end
            end
            OP_INV_D_LINE:
            begin
              r_next.dc_valid[in_line] = 1'b0;
              r_next.dirty_lo[in_line] = 1'b0;
              r_next.dirty_hi[in_line] = 1'b0;
              r_next.done = 1'b1;
            end
            OP_INV_D_ALL:
            begin
              r_next.dc_valid = '0;
              r_next.dirty_lo = '0;
              r_next.dirty_hi = '0;
              r_next.done = 1'b1;
            end
            OP_INV_I_ALL, OP_INV_I_LINE:
            begin
              r_next.ic_pend = 1'b1;
              r_next.ic_cnt  = IFETCH_AHEAD;
              r_next.ic_all  = (in_op == OP_INV_I_ALL);
              r_next.ic_line = in_line;
              r_next.done    = 1'b1;
            end
            OP_SET_BASE:
            begin
              r_next.base   = I_DATA[IDX_W-1:0];
              r_next.victim = I_DATA[IDX_W-1:0];
              r_next.done   = 1'b1;
            end
            OP_SET_PID:
            begin
              // Only the address mapping moves; no line state is touched
              r_next.pid  = I_DATA;
              r_next.done = 1'b1;
            end
            OP_SET_CTRL:
            begin
              r_next.dc_en = I_DATA[CTRL_DC_BIT];
              r_next.ic_en = I_DATA[CTRL_IC_BIT];
              r_next.done  = 1'b1;
            end
            default:
            begin
              r_next.done = 1'b1;
            end
          endcase
        end
      end
      ST_WB_READ:
      begin
        // Address bit 5 equals segment bit 0, so 26 stored bits rebuild it
        if (r_reg.dirty_lo[cur_line] && r_reg.dirty_hi[cur_line])
        begin
          r_next.wb_len  = WB_LEN_FULL;
          r_next.wb_addr = {tag_bus.rd_tag, r_reg.seg[0], LINE_OFFSET};
        end
        else if (r_reg.dirty_lo[cur_line])
        begin
          r_next.wb_len  = WB_LEN_HALF;
          r_next.wb_addr = {tag_bus.rd_tag, r_reg.seg[0], LINE_OFFSET};
        end
        else
        begin
          r_next.wb_len  = WB_LEN_HALF;
          r_next.wb_addr = {tag_bus.rd_tag, r_reg.seg[0], HALF_OFFSET};
        end
        r_next.fsm = ST_WB_BUS;
      end
      ST_WB_BUS:
      begin
        if (I_WB_DONE)
        begin
          r_next.dirty_lo[cur_line] = 1'b0;
          r_next.dirty_hi[cur_line] = 1'b0;
          r_next.fsm = (r_reg.op == OP_LINEFILL) ? ST_FILL : ST_FINISH;
        end
      end
      ST_FILL:
      begin
        if (I_FILL_DONE)
        begin
          r_next.dc_valid[cur_line] = 1'b1;
          r_next.dirty_lo[cur_line] = 1'b0;
          r_next.dirty_hi[cur_line] = 1'b0;
          r_next.dc_wb[cur_line]    = r_reg.wb_attr;
          r_next.victim = (r_reg.victim == IDX_MAX) ? r_reg.base
                                                    : r_reg.victim + 6'h01;
          r_next.done = 1'b1;
          r_next.fsm  = ST_IDLE;
        end
      end
      ST_FINISH:
      begin
        if (is_inv(r_reg.op))
        begin
          r_next.dc_valid[cur_line] = 1'b0;
        end
        r_next.done = 1'b1;
        r_next.fsm  = ST_IDLE;
      end
      default:
      begin
        r_next.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      r_reg        <= '0;
      r_reg.fsm    <= ST_IDLE;
      r_reg.op     <= OP_NOP;
      r_reg.base   <= BASE_RST;
      r_reg.victim <= VICTIM_RST;
      r_reg.pid    <= PID_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign O_OP_READY    = (r_reg.fsm == ST_IDLE);
  assign O_OP_DONE     = r_reg.done;
  assign O_USE_CACHE   = r_reg.use_cache;
  assign O_CACHE_WR    = r_reg.cache_wr;
  assign O_BUS_RD      = r_reg.bus_rd;
  assign O_BUS_WR      = r_reg.bus_wr;
  assign O_WB_REQ      = (r_reg.fsm == ST_WB_BUS);
  assign O_WB_ADDR     = r_reg.wb_addr;
  assign O_WB_LEN      = r_reg.wb_len;
  assign O_FILL_REQ    = (r_reg.fsm == ST_FILL);
  assign O_FILL_LINE   = cur_line;
  assign O_DC_EN       = r_reg.dc_en;
  assign O_IC_EN       = r_reg.ic_en;
  assign O_BASE        = r_reg.base;
  assign O_VICTIM      = r_reg.victim;
  assign O_PID         = r_reg.pid;
  assign O_LK_DC_VALID = r_reg.lk_dc_valid;
  assign O_LK_DC_DIRTY = r_reg.lk_dc_dirty;
  assign O_LK_IC_VALID = r_reg.lk_ic_valid;
endmodule : dcache_coherence

// [bench/dcache_coherence_asserts.sv]
// Purpose: Port-level checks for the coherence controller
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bound to the dcache_coherence module by the bind below
`timescale 1ns/10ps
module dcache_coherence_asserts
  import dcache_coh_pkg::*;
(
  input wire logic             I_SYS_CLK,
  input wire logic             I_RST,
  input wire logic             I_OP_VALID,
  input wire logic [3:0]       I_OP_CODE,
  input wire logic [7:0]       I_DATA,
  input wire logic             I_CACHEABLE,
  input wire logic             I_WB_DONE,
  input wire logic             O_OP_READY,
  input wire logic             O_OP_DONE,
  input wire logic             O_USE_CACHE,
  input wire logic             O_CACHE_WR,
  input wire logic             O_BUS_RD,
  input wire logic             O_BUS_WR,
  input wire logic             O_WB_REQ,
  input wire logic [3:0]       O_WB_LEN,
  input wire logic             O_DC_EN,
  input wire logic             O_IC_EN,
  input wire logic [IDX_W-1:0] O_BASE,
  input wire logic [IDX_W-1:0] O_VICTIM
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  logic       take;
  logic [7:0] data_reg;
  assign take = I_OP_VALID && O_OP_READY;
  // Operand copy so the base check sees the value of the taking edge
  always_ff @(posedge I_SYS_CLK)
    data_reg <= I_DATA;
  property p_rst_clear;
    disable iff (1'b0) I_RST |=> !O_DC_EN && !O_IC_EN && O_BASE == 6'h00 && O_VICTIM == 6'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset state wrong");
  property p_base_load;
    take && I_OP_CODE == 4'hD |=> O_BASE == data_reg[5:0] && O_VICTIM == data_reg[5:0];
  endproperty
  a_base_load: assert property (p_base_load) else $error("base or victim not loaded");
  property p_va_victim;
    take && (I_OP_CODE == 4'h7 || I_OP_CODE == 4'h8) |=> $stable(O_VICTIM) [*2];
  endproperty
  a_va_victim: assert property (p_va_victim) else $error("victim moved by address clean");
  property p_pid_quiet;
    take && I_OP_CODE == 4'hE |=> $stable(O_BASE) && $stable(O_VICTIM) && $stable(O_DC_EN);
  endproperty
  a_pid_quiet: assert property (p_pid_quiet) else $error("process id change touched state");
  property p_single_done;
    take && I_OP_CODE >= 4'h9 |=> O_OP_DONE;
  endproperty
  a_single_done: assert property (p_single_done) else $error("maintenance op not done");
  property p_wb_len;
    O_WB_REQ |-> O_WB_LEN == WB_LEN_HALF || O_WB_LEN == WB_LEN_FULL;
  endproperty
  a_wb_len: assert property (p_wb_len) else $error("write-back length wrong");
  property p_wb_drop;
    O_WB_REQ && I_WB_DONE |=> !O_WB_REQ;
  endproperty
  a_wb_drop: assert property (p_wb_drop) else $error("write-back request held");
  property p_unc_rd;
    take && I_OP_CODE == 4'h1 && !I_CACHEABLE |=> O_BUS_RD && !O_USE_CACHE;
  endproperty
  a_unc_rd: assert property (p_unc_rd) else $error("uncached read used cache");
  property p_unc_wr;
    take && I_OP_CODE == 4'h2 && !I_CACHEABLE |=> O_BUS_WR && O_CACHE_WR;
  endproperty
  a_unc_wr: assert property (p_unc_wr) else $error("uncached write not on both");
  c_base: cover property (take && I_OP_CODE == 4'hD);
  c_wb: cover property (O_WB_REQ && I_WB_DONE);
  c_unc: cover property (O_BUS_RD);
endmodule : dcache_coherence_asserts
bind dcache_coherence dcache_coherence_asserts u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_OP_VALID(I_OP_VALID), .I_OP_CODE(I_OP_CODE), .I_DATA(I_DATA), .I_CACHEABLE(I_CACHEABLE),
  .I_WB_DONE(I_WB_DONE), .O_OP_READY(O_OP_READY), .O_OP_DONE(O_OP_DONE),
  .O_USE_CACHE(O_USE_CACHE), .O_CACHE_WR(O_CACHE_WR), .O_BUS_RD(O_BUS_RD),
  .O_BUS_WR(O_BUS_WR), .O_WB_REQ(O_WB_REQ), .O_WB_LEN(O_WB_LEN), .O_DC_EN(O_DC_EN),
  .O_IC_EN(O_IC_EN), .O_BASE(O_BASE), .O_VICTIM(O_VICTIM));

// [bench/bus_if_model.sv]
// Purpose: Bus interface answering write-back and linefill requests
// Assumes: Requests hold until the done pulse
// Notes:   LAT sets the answer delay; larger values model a slow bus
`timescale 1ns/10ps
module bus_if_model #(parameter int LAT = 3)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_wb_req,
  input  wire logic i_fill_req,
  output logic      o_wb_done,
  output logic      o_fill_done
);
  int cnt;
  always_ff @(posedge i_clk)
  begin
    o_wb_done   <= 1'b0;
    o_fill_done <= 1'b0;
    if (i_rst || o_wb_done || o_fill_done || !(i_wb_req || i_fill_req))
      cnt <= 0;
    else if (cnt == LAT)
    begin
      o_wb_done   <= i_wb_req;
      o_fill_done <= i_fill_req;
      cnt         <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : bus_if_model

// [bench/dcache_coherence_tb_top.sv]
// Purpose: Directed scenarios for the coherence controller
// Assumes: One op in flight; each op waited on until done
// Notes:   Scan inputs are tied off; the fetch pulse is driven
`timescale 1ns/10ps
module dcache_coherence_tb_top
  import dcache_coh_pkg::*;
;
  localparam logic [31:0] FILL_PA = 32'h1234_5660;
  logic clk, rst, vld, cc, bb, hi, wb_done, fill_done, ten, twr, rdy, done, use_c;
  logic c_wr, b_rd, b_wr, wb_req, fill_req, dc_en, ic_en, ifx, lk_dc, lk_dirty, lk_ic;
  logic [3:0] code, wb_len, wb_l;
  logic [2:0] seg;
  logic [5:0] idx, base, victim;
  logic [7:0] dat, pid;
  logic [8:0] tline, fill_line, fl_q;
  logic [25:0] twd, trd;
  logic [31:0] wb_addr, wb_a;
  int wb_n = 0, mismatches = 0, compares = 0;
  dcache_coherence dut (.I_SYS_CLK(clk), .I_RST(rst), .I_OP_VALID(vld), .I_OP_CODE(code),
    .I_SEG(seg), .I_INDEX(idx), .I_PA(FILL_PA), .I_DATA(dat), .I_CACHEABLE(cc),
    .I_BUFFERABLE(bb), .I_HALF_HI(hi), .I_IFETCH(ifx), .O_OP_READY(rdy), .O_OP_DONE(done),
    .O_USE_CACHE(use_c), .O_CACHE_WR(c_wr), .O_BUS_RD(b_rd), .O_BUS_WR(b_wr),
    .O_WB_REQ(wb_req), .O_WB_ADDR(wb_addr), .O_WB_LEN(wb_len), .I_WB_DONE(wb_done),
    .O_FILL_REQ(fill_req), .O_FILL_LINE(fill_line), .I_FILL_DONE(fill_done),
    .O_DC_EN(dc_en), .O_IC_EN(ic_en), .O_BASE(base), .O_VICTIM(victim), .O_PID(pid),
    .O_LK_DC_VALID(lk_dc), .O_LK_DC_DIRTY(lk_dirty), .O_LK_IC_VALID(lk_ic), .I_TEST_EN(ten),
    .I_TEST_WR(twr), .I_TEST_LINE(tline), .I_TEST_WDATA(twd), .O_TEST_RDATA(trd),
    .I_SCAN_SHIFT(1'b0), .I_SCAN_IN(1'b0), .I_SCAN_CAPTURE(1'b0), .I_SCAN_UPDATE(1'b0),
    .O_SCAN_OUT());
  bus_if_model #(.LAT(3)) bus (.i_clk(clk), .i_rst(rst), .i_wb_req(wb_req),
    .i_fill_req(fill_req), .o_wb_done(wb_done), .o_fill_done(fill_done));
  // Record each finished write-back and the line being filled
  always @(posedge clk)
  begin
    if (wb_req === 1'b1 && wb_done === 1'b1)
    begin
      wb_n <= wb_n + 1;
      wb_a <= wb_addr;
      wb_l <= wb_len;
    end
    if (fill_req === 1'b1)
      fl_q <= fill_line;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask : chk
  // Holds the request one edge (ready is high in idle), then waits for done
  task automatic do_op(input logic [3:0] c, input logic [8:0] ln, input logic [7:0] d,
                       input logic [2:0] a);
    int n;
    @(posedge clk);
    #1;
    vld = 1'b1;
    code = c;
    {seg, idx} = ln;
    dat = d;
    {cc, bb, hi} = a;
    @(posedge clk);
    #1;
    vld = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 200)
    begin
      mismatches++;
      $display("wrong value at %0t: op never finished", $time);
      tally_and_finish();
    end
    chk(rdy, 1, "ready with done");
  endtask : do_op
  task automatic t_control();
    chk(dc_en, 0, "dc enable");
    chk(victim, 0, "victim after reset");
    do_op(4'hF, 9'h000, 8'h03, 3'b000);
    chk({ic_en, dc_en}, 2'b11, "cache enables");
    do_op(4'hE, 9'h000, 8'hA5, 3'b000);
    chk(pid, 8'hA5, "process id");
    do_op(4'hD, 9'h000, 8'h3C, 3'b000);
    chk({base, victim}, {6'h3C, 6'h3C}, "base and victim");
    $display("test control done");
  endtask : t_control
  task automatic t_fill_clean();
    int n0;
    do_op(4'h3, 9'h040, 8'h00, 3'b110);
    chk(fl_q, 9'h07C, "fill line at victim");
    chk(victim, 6'h3D, "victim advance");
    do_op(4'h2, 9'h07C, 8'h00, 3'b111);
    chk(b_wr, 0, "write-back store stays local");
    @(posedge clk);
    #1;
    chk(lk_dirty, 1, "store marked line dirty");
    n0 = wb_n;
    do_op(4'h7, 9'h07C, 8'h00, 3'b110);
    chk(wb_n, n0 + 1, "clean wrote back");
    chk(lk_dirty, 0, "clean cleared dirty");
    chk(wb_a, {FILL_PA[31:6], 1'b1, HALF_OFFSET}, "wb address");
    chk(wb_l, WB_LEN_HALF, "wb length");
    chk(victim, 6'h3D, "victim after address clean");
    do_op(4'h7, 9'h07C, 8'h00, 3'b110);
    chk(wb_n, n0 + 1, "clean line no write");
    $display("test fill_clean done");
  endtask : t_fill_clean
  task automatic t_uncached();
    do_op(4'h8, 9'h07C, 8'h00, 3'b110);
    @(posedge clk);
    #1;
    chk(lk_dc, 0, "line invalid after clean-invalidate");
    do_op(4'h1, 9'h07C, 8'h00, 3'b000);
    chk({b_rd, use_c}, 2'b10, "uncached read");
    do_op(4'h2, 9'h07C, 8'h00, 3'b000);
    chk({b_wr, c_wr}, 2'b11, "uncached write");
    for (int k = 9; k < 13; k++)
      do_op(k[3:0], 9'h07C, 8'h00, 3'b000);
    $display("test uncached done");
  endtask : t_uncached
  task automatic t_tag();
    @(posedge clk);
    #1;
    ten = 1'b1;
    tline = 9'h07C;
    @(posedge clk);
    #1;
    chk(trd, FILL_PA[31:6], "stored tag");
    twr = 1'b1;
    tline = 9'h05A;
    twd = 26'h2ABCDEF;
    @(posedge clk);
    #1;
    twr = 1'b0;
    @(posedge clk);
    #1;
    chk(trd, 26'h2ABCDEF, "test port readback");
    $display("test tag done");
  endtask : t_tag
  task automatic t_soft();
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 2; i++)
        do_op(i ? 4'h6 : 4'h5, {s[2:0], i[5:0]}, 8'h00, 3'b110);
    chk(victim, 6'h01, "victim at index used");
    do_op(4'hD, 9'h000, 8'h3C, 3'b000);
    chk(victim, 6'h3C, "victim restored");
    do_op(4'h4, 9'h0C5, 8'h00, 3'b000);
    do_op(4'hC, 9'h0C5, 8'h00, 3'b000);
    ifx = 1'b1;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      chk(lk_ic, 1, "line kept for prefetched fetches");
    end
    ifx = 1'b0;
    @(posedge clk);
    #1;
    chk(lk_ic, 0, "line gone after third fetch");
    do_op(4'h4, 9'h0C5, 8'h00, 3'b000);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    chk({lk_ic, ic_en, dc_en}, 3'b000, "state after mid-run reset");
    $display("test soft done");
  endtask : t_soft
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    {rst, vld, cc, bb, hi, ten, twr, ifx} = 8'h80;
    {code, seg, idx, dat, tline, twd} = '0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_control();
    t_fill_clean();
    t_uncached();
    t_tag();
    t_soft();
    tally_and_finish();
  end
endmodule : dcache_coherence_tb_top
